// ===== design/asr_consts.vh
// Constants and operation summary of the serial converter readout block
// Operation
// - Frame select falling starts a conversion and enters normal mode.
// - Frame select rising after falling edge two, before edge ten, enters shutdown.
// - Early rise to shutdown abandons conversion and floats serial output.
// - Frame select rising before second falling edge keeps mode unchanged.
// - Rise after tenth before sixteenth keeps normal, aborts, floats output.
// - Word spans sixteen clock cycles; output floats after the sixteenth.
// - Shutdown persists with analog off until frame select goes low.
// - Select low wakes device; first result unusable, second valid.
// - During wake-up frame, rise before tenth edge returns to shutdown.
// - Device fully powered after sixteen clock cycles of wake-up frame.
// - Results are 12-bit straight binary codes, step is supply over 4096.
// - Three zeros then twelve result bits, MSB first, on falling edges.
// - Select fall drives output and samples; tracking from 13th rising edge.
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH
`define ASR_DATA_W        12
`define ASR_CNT_W         5
`define ASR_EDGE_MIN_SD   5'h02
`define ASR_EDGE_MAX_SD   5'h0a
`define ASR_EDGE_WORD     5'h10
`define ASR_LEAD_ZEROS    5'h03
`define ASR_EDGE_TRACK    5'h0d
`define ASR_ACQ_NS        350
`define ASR_CLK_NS        10
`define ASR_ACQ_CYC       ((`ASR_ACQ_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`endif

// ===== design/asr_sync.v
// Two-flop synchroniser with edge detection after the second stage
`include "asr_consts.vh"
module asr_sync (
  input  wire clk,
  input  wire rst,
  input  wire din,
  output reg  level,
  output reg  rise,
  output reg  fall
);
  reg stage1Reg;
  reg stage2Reg;
  reg stage3Reg;

  always @(posedge clk) begin
    if (rst) begin
      stage1Reg <= 1'b1;
      stage2Reg <= 1'b1;
      stage3Reg <= 1'b1;
      level     <= 1'b1;
      rise      <= 1'b0;
      fall      <= 1'b0;
    end else begin
      stage1Reg <= din;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      level     <= stage2Reg;
      rise      <= stage2Reg & ~stage3Reg;
      fall      <= ~stage2Reg & stage3Reg;
    end
  end
endmodule // asr_sync

// ===== design/asr_adc_serial.v
// Serial readout and power-mode control of the 12-bit converter
`include "asr_consts.vh"
module asr_adc_serial (
  input  wire                    clk,
  input  wire                    rst,
  input  wire                    frameSelN,
  input  wire                    serialClk,
  input  wire [`ASR_DATA_W-1:0]  sampleIn,
  output reg                     serialOut,
  output reg                     serialOutEnN,
  output reg                     shutdownMode,
  output reg                     powerReady,
  output reg                     sampleHold,
  output reg                     resultValid
);
  // Frame states, one-hot
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_FRAME = 2'b10;

  // What a rise of select means, decided from the falls seen
  localparam [1:0] RISE_KEEP  = 2'b00;
  localparam [1:0] RISE_SLEEP = 2'b01;
  localparam [1:0] RISE_TRUNC = 2'b10;

  // Pin order in the synchroniser bank
  localparam integer PIN_SEL  = 0;
  localparam integer PIN_SCLK = 1;
  localparam integer PIN_NUM  = 2;

  wire [PIN_NUM-1:0]     pinIn;
  wire [PIN_NUM-1:0]     pinRise;
  wire [PIN_NUM-1:0]     pinFall;
  wire                   selRise;
  wire                   selFall;
  wire                   sclkRise;
  wire                   sclkFall;
  reg  [1:0]             state_reg;
  reg  [1:0]             state_next;
  reg  [`ASR_CNT_W-1:0]  edgeCnt_reg;
  reg  [`ASR_CNT_W-1:0]  edgeCnt_next;
  reg  [`ASR_CNT_W-1:0]  risingCnt_reg;
  reg  [`ASR_CNT_W-1:0]  risingCnt_next;
  reg  [`ASR_DATA_W-1:0] shift_reg;
  reg                    wakeFrame_reg;
  reg                    dummyPending_reg;
  reg  [1:0]             riseDecision;
  wire                   wordEnd;
  wire                   dataPhase;
  wire                   holdEnd;

  // Count below a limit; shared by rise and shift decisions
  function below;
    input [`ASR_CNT_W-1:0] cnt;
    input [`ASR_CNT_W-1:0] limit;
    begin
      below = (cnt < limit);
    end
  endfunction

  // Rise of select, judged by the falls counted so far
  function [1:0] riseAction;
    input [`ASR_CNT_W-1:0] cnt;
    input                  wake;
    begin
      if (wake && below(cnt, `ASR_EDGE_MAX_SD)) begin
        riseAction = RISE_SLEEP;
      end else if (below(cnt, `ASR_EDGE_MIN_SD)) begin
        riseAction = RISE_KEEP;
      end else if (below(cnt, `ASR_EDGE_MAX_SD)) begin
        riseAction = RISE_SLEEP;
      end else begin
        riseAction = RISE_TRUNC;
      end
    end
  endfunction

  assign pinIn[PIN_SEL]  = frameSelN;
  assign pinIn[PIN_SCLK] = serialClk;

  // Both pins idle high, so synchronisers reset high: no false edge
  genvar g;
  generate
    for (g = 0; g < PIN_NUM; g = g + 1) begin : gPinSync
      asr_sync uSync (
        .clk   (clk),
        .rst   (rst),
        .din   (pinIn[g]),
        .level (),
        .rise  (pinRise[g]),
        .fall  (pinFall[g])
      );
    end
  endgenerate

  assign selRise  = pinRise[PIN_SEL];
  assign selFall  = pinFall[PIN_SEL];
  assign sclkRise = pinRise[PIN_SCLK];
  assign sclkFall = pinFall[PIN_SCLK];

  // Decodes of the counts after this cycle's edges
  assign wordEnd   = sclkFall & ~below(edgeCnt_next, `ASR_EDGE_WORD);
  assign dataPhase = ~below(edgeCnt_next, `ASR_LEAD_ZEROS);
  assign holdEnd   = sclkRise & (risingCnt_next == `ASR_EDGE_TRACK);

  // Frame sequencing and edge counters
  always @* begin
    state_next     = state_reg;
    edgeCnt_next   = edgeCnt_reg;
    risingCnt_next = risingCnt_reg;
    riseDecision   = riseAction(edgeCnt_reg, wakeFrame_reg);
    case (state_reg)
      ST_IDLE: begin
        if (selFall) begin
          state_next     = ST_FRAME;
          edgeCnt_next   = {`ASR_CNT_W{1'b0}};
          risingCnt_next = {`ASR_CNT_W{1'b0}};
        end
      end
      ST_FRAME: begin
        if (selRise) begin
          state_next = ST_IDLE;
        end else begin
          if (sclkFall && edgeCnt_reg != {`ASR_CNT_W{1'b1}}) begin
            edgeCnt_next = edgeCnt_reg + 5'h01;
          end
          if (sclkRise && risingCnt_reg != {`ASR_CNT_W{1'b1}}) begin
            risingCnt_next = risingCnt_reg + 5'h01;
          end
          if (sclkFall && !below(edgeCnt_next, `ASR_EDGE_WORD)) begin
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Outputs and mode, all registered
  always @(posedge clk) begin
    if (rst) begin
      state_reg        <= ST_IDLE;
      edgeCnt_reg      <= {`ASR_CNT_W{1'b0}};
      risingCnt_reg    <= {`ASR_CNT_W{1'b0}};
      shift_reg        <= {`ASR_DATA_W{1'b0}};
      wakeFrame_reg    <= 1'b0;
      dummyPending_reg <= 1'b0;
      serialOut        <= 1'b0;
      serialOutEnN     <= 1'b1;
      shutdownMode     <= 1'b0;
      powerReady       <= 1'b0;
      sampleHold       <= 1'b0;
      resultValid      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      edgeCnt_reg   <= edgeCnt_next;
      risingCnt_reg <= risingCnt_next;
      resultValid   <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (selFall) begin
            // Unknown mode after reset counts as a wake-up
            shutdownMode     <= 1'b0;
            wakeFrame_reg    <= shutdownMode | ~powerReady;
            dummyPending_reg <= shutdownMode | ~powerReady;
            shift_reg        <= sampleIn;
            sampleHold       <= 1'b1;
            serialOut        <= 1'b0;
            serialOutEnN     <= 1'b0;
          end
        end
        ST_FRAME: begin
          if (selRise) begin
            // Any rise inside a frame ends the word
            serialOutEnN  <= 1'b1;
            serialOut     <= 1'b0;
            sampleHold    <= 1'b0;
            wakeFrame_reg <= 1'b0;
            case (riseDecision)
              RISE_SLEEP: begin
                shutdownMode <= 1'b1;
                powerReady   <= 1'b0;
              end
              RISE_TRUNC: begin
                shutdownMode <= 1'b0;
              end
              default: begin
                shutdownMode <= shutdownMode;
              end
            endcase
          end else if (wordEnd) begin
            serialOutEnN     <= 1'b1;
            serialOut        <= 1'b0;
            sampleHold       <= 1'b0;
            wakeFrame_reg    <= 1'b0;
            dummyPending_reg <= 1'b0;
            if (wakeFrame_reg) begin
              powerReady  <= 1'b1;
            end else begin
              resultValid <= ~dummyPending_reg;
            end
          end else begin
            if (holdEnd) begin
              sampleHold <= 1'b0;
            end
            if (sclkFall && dataPhase) begin
              serialOut <= shift_reg[`ASR_DATA_W-1];
              shift_reg <= {shift_reg[`ASR_DATA_W-2:0], 1'b0};
            end else if (sclkFall) begin
              serialOut <= 1'b0;
            end
          end
        end
        default: begin
          serialOutEnN <= 1'b1;
        end
      endcase
    end
  end

endmodule // asr_adc_serial

// ===== bench/asr_chk_sva.sv
// Assertions on the converter readout ports
module asr_chk (
  input wire clk,
  input wire rst,
  input wire frameSelN,
  input wire serialOut,
  input wire serialOutEnN,
  input wire shutdownMode,
  input wire powerReady,
  input wire sampleHold,
  input wire resultValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_DRV: assert property ($fell(frameSelN) |-> ##[3:6] !serialOutEnN) else $error("drv");
  AST_HLD: assert property ($fell(frameSelN) |-> ##[3:6] sampleHold) else $error("hold");
  AST_FLT: assert property ($rose(frameSelN) |-> ##[2:6] serialOutEnN) else $error("flt");
  AST_SDK: assert property (shutdownMode && frameSelN |=> shutdownMode) else $error("sd");
  AST_ZRO: assert property ($fell(serialOutEnN) |-> !serialOut) else $error("zero");
  AST_RDY: assert property ($rose(powerReady) |-> !shutdownMode) else $error("rdy");
  AST_VLD: assert property (resultValid |-> ##[0:1] serialOutEnN) else $error("vld");
  AST_SDF: assert property ($rose(shutdownMode) |-> ##[0:2] serialOutEnN) else $error("sdf");
endmodule // asr_chk
bind asr_adc_serial asr_chk i_asr_chk (.*);

// ===== bench/asr_host.sv
// Host model driving select and serial clock
module asr_host (
  input  wire  clk,
  input  wire  serialOut,
  input  wire  serialOutEnN,
  output logic frameSelN = 1'b1,
  output logic serialClk = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [14:0] word;
  // Clock idles high, runs only in frames
  task automatic frame(input int n);
    @(negedge clk) frameSelN = 1'b0;
    for (int i = 1; i <= n; i++) begin
      repeat (6) @(negedge clk);
      if (i < 16) word = {word[13:0], serialOutEnN ? ~word[0] : serialOut};
      serialClk = 1'b0;
      repeat (7) @(negedge clk);
      serialClk = 1'b1;
    end
    repeat (3) @(negedge clk);
    frameSelN = 1'b1;
    repeat (50) @(negedge clk);
  endtask
endmodule // asr_host

// ===== bench/testbench.sv
// Self-checking bench for the converter readout
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] sampleIn = 12'h000;
  wire frameSelN, serialClk, serialOut, serialOutEnN;
  wire shutdownMode, powerReady, sampleHold, resultValid;
  int mismatches = 0;
  int compares = 0;
  int valids = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (resultValid === 1'b1) valids++;
  asr_adc_serial i_asr_adc_serial (
    .clk          (clk),
    .rst          (rst),
    .frameSelN    (frameSelN),
    .serialClk    (serialClk),
    .sampleIn     (sampleIn),
    .serialOut    (serialOut),
    .serialOutEnN (serialOutEnN),
    .shutdownMode (shutdownMode),
    .powerReady   (powerReady),
    .sampleHold   (sampleHold),
    .resultValid  (resultValid)
  );
  asr_host i_asr_host (
    .clk          (clk),
    .serialOut    (serialOut),
    .serialOutEnN (serialOutEnN),
    .frameSelN    (frameSelN),
    .serialClk    (serialClk)
  );
  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [2:0] e);
    chk({12'h000, shutdownMode, powerReady, serialOutEnN}, {12'h000, e});
  endtask
  task automatic t_word(input logic [11:0] v, input logic rdy0);
    int n0;
    n0 = valids;
    sampleIn = v;
    i_asr_host.frame(16);
    chk(i_asr_host.word, {3'b000, v});
    chk(15'(valids - n0), {14'h0000, rdy0});
    st(3'b011);
    chk({14'h0000, sampleHold}, 15'h0000);
    $display("t_word done");
  endtask
  task automatic t_abort;
    int n0;
    n0 = valids;
    i_asr_host.frame(1);
    st(3'b011);
    i_asr_host.frame(12);
    st(3'b011);
    chk(15'(valids - n0), 15'h0000);
    $display("t_abort done");
  endtask
  task automatic t_sd;
    i_asr_host.frame(2);
    chk({14'h0000, shutdownMode}, 15'h0001);
    i_asr_host.frame(1);
    chk({14'h0000, shutdownMode}, 15'h0001);
    i_asr_host.frame(11);
    st(3'b001);
    i_asr_host.frame(16);
    st(3'b011);
    $display("t_sd done");
  endtask
  task automatic print_verdict;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    st(3'b001);
    repeat (3) @(negedge clk);
    t_word(12'ha5c, 1'b0);
    chk({14'h0000, powerReady}, 15'h0001);
    t_word(12'hfff, 1'b1);
    t_abort;
    t_sd;
    t_word(12'h001, 1'b1);
    print_verdict;
  end
  initial begin
    #200us;
    mismatches++;
    print_verdict;
  end
endmodule // testbench
